/* File: verilog/mmx_defs.svh */
// Purpose: constants for the memory map and external code bus block
// Assumes: one 50 MHz clock, one core clock per oscillator period
// Notes: offsets, reset values, timing counts, the nop opcode and the latch off bit only
`ifndef MMX_DEFS_SVH
`define MMX_DEFS_SVH
`define MMX_INT_CODE_TOP 16'hf7ff
`define MMX_NOP_OPCODE 8'h00
`define MMX_BUS_PERIOD 3'h6
`define MMX_ALE_PHASE 3'h0
`define MMX_PROGRAM_STORE_STROBE_PHASE 3'h3
`define MMX_SP_RESET 11'h007
`define MMX_SP_WRAP_LO 11'h0ff
`define MMX_SP_EXT_BASE 11'h100
`define MMX_BANK_BYTES 8'h20
`define MMX_BIT_BASE 8'h20
`define MMX_UPPER_BASE 8'h80
`define MMX_LATCH_OFF_BIT 4
`endif

/* File: verilog/mmx_pkg.sv */
// Purpose: types shared by the memory map block
// Assumes: mmx_defs.svh holds the numbers
// Notes: no constants here
package mmx_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic req;
  } mmx_fetch_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic req;
  } mmx_xdata_t;
  typedef enum logic [1:0] {
    MMX_IDLE, MMX_CODE, MMX_DATA
  } mmx_bus_state_t;
endpackage : mmx_pkg

/* File: verilog/mmx_stack_ptr.sv */
// Purpose: stack pointer with optional 11-bit extension
// Assumes: push and pop never come in the same cycle
// Notes: load writes the low byte; the three extension bits take load_val with extension on, else zero
`timescale 1ns/10ps
`include "mmx_defs.svh"
module mmx_stack_ptr (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ext_enable,
  input wire logic push,
  input wire logic pop,
  input wire logic load,
  input wire logic [10:0] load_val,
  output logic [10:0] sp
);
  logic [10:0] sp_reg;
  logic [10:0] sp_next;
  logic [10:0] inc_val;
  logic [10:0] dec_val;
  // without extension the pointer stays 8 bits and wraps ff to 00
  assign inc_val = ext_enable ? sp_reg + 11'h001
                              : {3'h0, sp_reg[7:0] + 8'h01};
  assign dec_val = ext_enable ? sp_reg - 11'h001
                              : {3'h0, sp_reg[7:0] - 8'h01};
  // pre-increment: the written address is the new value
  assign sp_next = load ? (ext_enable ? load_val : {3'h0, load_val[7:0]}) :
                   push ? inc_val : pop ? dec_val : sp_reg;
  // pointer register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sp_reg <= `MMX_SP_RESET;
    end else begin
      sp_reg <= sp_next;
    end
  end
  assign sp = sp_reg;
endmodule : mmx_stack_ptr

/* File: verilog/mmx_memory_map.sv */
// Purpose: code source choice, external bus strobes and data RAM map
// Assumes: one core clock equals one oscillator period; pins synchronous
// Notes: port 0 pin is split into in, out and drive enable
// Operation
// - select pin high: internal fetch below f800; low: all external
// - code source sampled when reset ends or at power cycle
// - program strobe at most once per twelve periods, never during data access
// - program strobe stays high while running internal code
// - program strobe pulled low at reset release enters download mode
// - latch strobe every six periods, suppressed in data accesses
// - latch strobe off while power control bit 4 is set
// - port 0 is open drain; a latched one floats
// - port 0 carries address and data with strong ones as a bus
// - internal fetches from f800 to ffff return no-operation
// - low 128 bytes direct or indirect; upper 128 indirect only
// - lowest 32 bytes form four banks of eight working registers
// - bytes 20 to 2f are bit addressable as bits 00 to 7f
// - reset loads stack pointer 07; push pre-increments
// - stack may grow to 2048 bytes
// - extended stack enable widens pointer, wraps ff to 0100
// - port 2 gives high address byte; data gives middle and high
`timescale 1ns/10ps
`include "mmx_defs.svh"
module mmx_memory_map (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic external_access_select,
  input wire logic program_store_strobe_in,
  output logic program_store_strobe,
  output logic program_store_strobe_oe,
  output logic address_latch_strobe,
  input wire logic [7:0] port0_pins_in,
  output logic [7:0] port0_pins_out,
  output logic [7:0] port0_pins_oe,
  output logic [7:0] port2_pins,
  input wire logic [7:0] port0_latch,
  input wire logic [7:0] port2_latch,
  input wire logic [7:0] power_control_register,
  input wire logic extended_stack_enable,
  input wire mmx_pkg::mmx_fetch_t fetch,
  output logic fetch_ready,
  output logic [7:0] fetch_data,
  input wire logic [7:0] int_code_data,
  output logic [15:0] int_code_addr,
  input wire mmx_pkg::mmx_xdata_t xdata,
  output logic xdata_ready,
  output logic [7:0] xdata_rdata,
  output logic xdata_rd_n,
  output logic xdata_wr_n,
  output logic external_code_mode,
  output logic download_mode,
  input wire logic ram_we,
  input wire logic ram_indirect,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata,
  output logic sfr_select,
  input wire logic [1:0] bank_select,
  input wire logic [2:0] work_reg_num,
  output logic [7:0] work_reg_addr,
  input wire logic [6:0] bit_addr,
  output logic bit_value,
  input wire logic bit_we,
  input wire logic bit_wdata,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic stack_load,
  input wire logic [10:0] stack_load_val,
  output logic [10:0] stack_pointer_register
);
  // ****************************************************************
  // boot strap capture
  // ****************************************************************
  logic boot_done_reg;
  logic ext_mode_reg;
  logic dl_mode_reg;
  logic strap_sample;
  // the single strap window: the first edge after reset lets go
  assign strap_sample = ~boot_done_reg;
  // straps caught on the first clock after release, then frozen
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boot_done_reg <= 1'b0;
      ext_mode_reg <= 1'b0;
      dl_mode_reg <= 1'b0;
    end else if (strap_sample) begin
      boot_done_reg <= 1'b1;
      ext_mode_reg <= ~external_access_select;
      dl_mode_reg <= ~program_store_strobe_in;
    end
  end
  // later pin levels are ignored until the next reset
  assign external_code_mode = ext_mode_reg;
  assign download_mode = dl_mode_reg;

  // ****************************************************************
  // six period bus cycle sequencer
  // ****************************************************************
  mmx_pkg::mmx_bus_state_t state_reg;
  mmx_pkg::mmx_bus_state_t state_next;
  logic [2:0] phase_reg;
  logic [15:0] code_addr_reg;
  logic [23:0] data_addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg;
  logic [7:0] fetch_data_reg;
  logic [7:0] xdata_rdata_reg;
  logic phase_last;
  logic in_data;
  logic in_code;
  logic ext_fetch;
  logic int_fetch;
  logic int_fetch_high;
  logic in_idle;
  logic take_cycle;
  logic code_done;
  logic data_done;
  // the phase counter free-runs so the latch strobe keeps its beat
  assign phase_last = phase_reg == (`MMX_BUS_PERIOD - 3'h1);
  assign in_idle = state_reg == mmx_pkg::MMX_IDLE;
  assign in_data = state_reg == mmx_pkg::MMX_DATA;
  assign in_code = state_reg == mmx_pkg::MMX_CODE;
  // requests are only taken at a cycle boundary with the bus free
  assign take_cycle = phase_last & in_idle;
  assign code_done = phase_last & in_code;
  assign data_done = phase_last & in_data;
  // fetches leave the chip only when the strap chose external code
  assign ext_fetch = fetch.req & ext_mode_reg;
  assign int_fetch = fetch.req & ~ext_mode_reg;
  // above the internal top the program counter must not reach outside
  assign int_fetch_high = fetch.addr > `MMX_INT_CODE_TOP;
  // next bus state chosen at each cycle boundary; data access wins
  always_comb begin
    state_next = state_reg;
    if (phase_last) begin
      if (xdata.req && state_reg == mmx_pkg::MMX_IDLE) begin
        state_next = mmx_pkg::MMX_DATA;
      end else if (ext_fetch && state_reg == mmx_pkg::MMX_IDLE) begin
        state_next = mmx_pkg::MMX_CODE;
      end else begin
        state_next = mmx_pkg::MMX_IDLE;
      end
    end
  end
  // sequencer registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= mmx_pkg::MMX_IDLE;
      phase_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_last ? 3'h0 : phase_reg + 3'h1;
    end
  end
  // addresses and write data are frozen for the whole bus cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      code_addr_reg <= 16'h0000;
      data_addr_reg <= 24'h000000;
      wdata_reg <= 8'h00;
      wr_reg <= 1'b0;
    end else if (take_cycle) begin
      code_addr_reg <= fetch.addr;
      data_addr_reg <= xdata.addr;
      wdata_reg <= xdata.wdata;
      wr_reg <= xdata.wr;
    end
  end
  // code byte: port 0 at the end of an external cycle, else the array;
  // the nop substitution hides whatever sits above the internal top
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetch_data_reg <= 8'h00;
    end else if (code_done) begin
      fetch_data_reg <= port0_pins_in;
    end else if (int_fetch) begin
      fetch_data_reg <= int_fetch_high ? `MMX_NOP_OPCODE
                                       : int_code_data;
    end
  end
  // read data is taken while the memory still drives port 0
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      xdata_rdata_reg <= 8'h00;
    end else if (data_done) begin
      xdata_rdata_reg <= port0_pins_in;
    end
  end
  // internal fetch answers the cycle after request; external at cycle end
  logic int_ready_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_ready_reg <= 1'b0;
    end else begin
      int_ready_reg <= int_fetch & ~int_ready_reg;
    end
  end
  assign fetch_ready = ext_mode_reg ? code_done : int_ready_reg;
  assign xdata_ready = data_done;
  assign fetch_data = fetch_data_reg;
  assign xdata_rdata = xdata_rdata_reg;
  assign int_code_addr = fetch.addr;

  // ****************************************************************
  // strobes and ports
  // ****************************************************************
  logic ale_window;
  logic program_store_strobe_window;
  logic addr_phase;
  logic bus_active;
  logic latch_off;
  logic code_strobe;
  logic read_strobe;
  logic write_strobe;
  logic [7:0] p0_addr_byte;
  logic [7:0] p0_bus_byte;
  logic [7:0] p0_bus_oe;
  logic [7:0] p2_data_byte;
  // phase decode shared by every strobe
  assign ale_window = phase_reg == `MMX_ALE_PHASE;
  assign program_store_strobe_window = phase_reg >= `MMX_PROGRAM_STORE_STROBE_PHASE;
  assign addr_phase = phase_reg < `MMX_PROGRAM_STORE_STROBE_PHASE;
  assign bus_active = in_code | in_data;
  // latch strobe beats every six periods, silent in data cycles or if off;
  // kept low under reset, where the frozen phase would hold it high
  assign latch_off = power_control_register[`MMX_LATCH_OFF_BIT];
  assign address_latch_strobe = ale_window & ~in_data
    & ~latch_off & ~rst;
  // program strobe active low only in external code cycles
  assign code_strobe = in_code & program_store_strobe_window;
  assign program_store_strobe = ~code_strobe;
  // held high during internal execution, released while straps sampled
  assign program_store_strobe_oe = boot_done_reg;
  // data strobes only exist in data cycles, so they never meet the
  // program strobe
  assign read_strobe = in_data & ~wr_reg & program_store_strobe_window;
  assign write_strobe = in_data & wr_reg & program_store_strobe_window;
  assign xdata_rd_n = ~read_strobe;
  assign xdata_wr_n = ~write_strobe;
  // port 0 as a bus: address first, then write data, ones driven hard
  assign p0_addr_byte = in_code ? code_addr_reg[7:0] : data_addr_reg[7:0];
  assign p0_bus_byte = addr_phase ? p0_addr_byte : wdata_reg;
  assign p0_bus_oe = {8{addr_phase | (in_data & wr_reg)}};
  // outside the bus a latched one floats, so only zeros are driven
  assign port0_pins_out = bus_active ? p0_bus_byte : 8'h00;
  assign port0_pins_oe = bus_active ? p0_bus_oe : ~port0_latch;
  // port 2: high code byte; a data cycle shows the page byte while the
  // address stands and the middle byte under the strobes
  assign p2_data_byte = addr_phase ? data_addr_reg[23:16]
                                   : data_addr_reg[15:8];
  assign port2_pins = in_code ? code_addr_reg[15:8] :
    in_data ? p2_data_byte : port2_latch;

  // ****************************************************************
  // internal data RAM map
  // ****************************************************************
  logic [7:0] ram_mem [0:255];
  logic ram_direct_hit;
  logic [7:0] bit_byte_addr;
  logic byte_write;
  logic bit_write;
  // direct addresses 80 and up go to special registers, not RAM
  assign sfr_select = ~ram_indirect & ram_addr[7];
  assign ram_direct_hit = ram_indirect | ~ram_addr[7];
  // bank select times eight plus register number
  assign work_reg_addr = {3'h0, bank_select, work_reg_num};
  // sixteen bit bytes from 20, eight bits each
  assign bit_byte_addr = `MMX_BIT_BASE + {4'h0, bit_addr[6:3]};
  assign bit_value = ram_mem[bit_byte_addr][bit_addr[2:0]];
  // writes: byte port has priority over bit port in the same cycle;
  // a direct write into the upper half belongs to the special registers
  assign byte_write = ram_we & ram_direct_hit;
  assign bit_write = bit_we & ~byte_write;
  always_ff @(posedge ref_clk) begin
    if (byte_write) begin
      ram_mem[ram_addr] <= ram_wdata;
    end else if (bit_write) begin
      ram_mem[bit_byte_addr][bit_addr[2:0]] <= bit_wdata;
    end
  end
  // registered read keeps the data output on a flip-flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ram_rdata <= 8'h00;
    end else if (ram_direct_hit) begin
      ram_rdata <= ram_mem[ram_addr];
    end
  end

  // ****************************************************************
  // stack pointer
  // ****************************************************************
  mmx_stack_ptr u_sp (
    .ref_clk(ref_clk),
    .rst(rst),
    .ext_enable(extended_stack_enable),
    .push(stack_push),
    .pop(stack_pop),
    .load(stack_load),
    .load_val(stack_load_val),
    .sp(stack_pointer_register)
  );
endmodule : mmx_memory_map

/* File: tb/mmx_props.sv */
// Purpose: port-level checks of the memory map block
// Assumes: one clock domain, reset async high
// Notes: bound onto every mmx_memory_map instance
`timescale 1ns/10ps
module mmx_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic program_store_strobe,
  input wire logic address_latch_strobe,
  input wire logic [7:0] power_control_register,
  input wire logic external_code_mode,
  input wire mmx_pkg::mmx_fetch_t fetch,
  input wire logic fetch_ready,
  input wire logic [7:0] fetch_data,
  input wire logic xdata_rd_n,
  input wire logic xdata_wr_n,
  input wire logic ram_indirect,
  input wire logic [7:0] ram_addr,
  input wire logic sfr_select,
  input wire logic [1:0] bank_select,
  input wire logic [2:0] work_reg_num,
  input wire logic [7:0] work_reg_addr,
  input wire logic stack_push,
  input wire logic extended_stack_enable,
  input wire logic [10:0] stack_pointer_register
);
  // ****************************
  // bus, map and stack checks
  // ****************************
  logic [7:0] sp_lo; // slice kept as a net so $past sees a plain signal
  assign sp_lo = stack_pointer_register[7:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_program_store_strobe_internal: assert property (
    !external_code_mode |-> program_store_strobe) else $error("program_store_strobe low");
  a_ale_off: assert property (
    power_control_register[4] |-> !address_latch_strobe) else $error("ale on");
  a_ale_period: assert property (
    address_latch_strobe |=> !address_latch_strobe [*5]) else $error("ale gap");
  a_strobe_excl: assert property (
    !(xdata_rd_n && xdata_wr_n) |-> program_store_strobe && !address_latch_strobe)
    else $error("strobe overlap");
  a_nop_top: assert property (
    fetch_ready && !external_code_mode && fetch.addr > 16'hf7ff
    |=> fetch_data == 8'h00) else $error("no nop");
  a_sfr_map: assert property (
    sfr_select == (!ram_indirect && ram_addr[7])) else $error("sfr decode");
  a_bank_map: assert property (
    work_reg_addr == {3'h0, bank_select, work_reg_num}) else $error("bank");
  a_sp_push: assert property (
    stack_push && !extended_stack_enable |=> sp_lo == $past(sp_lo) + 8'h01)
    else $error("push step");
  a_sp_wrap: assert property (
    stack_push && extended_stack_enable && stack_pointer_register == 11'h0ff
    |=> stack_pointer_register == 11'h100) else $error("stack wrap");
  a_mode_held: assert property (
    !$past(rst) && !$past(rst, 2) |-> $stable(external_code_mode))
    else $error("mode moved");
  c_ext_fetch: cover property (fetch_ready && external_code_mode);
  c_data_rd: cover property (!xdata_rd_n);
  c_sp_wrap: cover property (stack_pointer_register == 11'h100);
endmodule : mmx_props
bind mmx_memory_map mmx_props i_mmx_props (.*);

/* File: tb/mmx_ext_mem.sv */
// Purpose: external code and data memory on the multiplexed bus
// Assumes: code byte is the inverse of high xor low address
// Notes: data side is one byte; address is not decoded there
`timescale 1ns/10ps
module mmx_ext_mem (
  input wire logic ref_clk,
  input wire logic ale,
  input wire logic program_store_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] ad,
  input wire logic [7:0] hi,
  output logic drive,
  output logic [7:0] q
);
  // ****************************
  // latch and storage
  // ****************************
  logic [15:0] addr_reg;
  logic [7:0] data_reg;
  // the latch strobe captures low byte while port 2 carries the high byte
  always_ff @(posedge ref_clk) begin
    if (ale) addr_reg <= {hi, ad};
    if (!wr_n) data_reg <= ad;
  end
  // drives only under a read strobe; otherwise the pull-up wins
  assign drive = !program_store_strobe_n || !rd_n;
  assign q = !program_store_strobe_n ? ~(addr_reg[15:8] ^ addr_reg[7:0]) : data_reg;
endmodule : mmx_ext_mem

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the memory map block
// Assumes: 50 MHz clock, external memory model on the bus
// Notes: select pin only changes while reset is held
`timescale 1ns/10ps
module tb_top;
  // ****************************
  // signals and instances
  // ****************************
  logic ref_clk = 1'b0, rst = 1'b1, external_access_select = 1'b1;
  logic program_store_strobe_strap = 1'b1, ram_we = 1'b0, ram_indirect = 1'b0;
  logic extended_stack_enable = 1'b0, bit_we = 1'b0, bit_wdata = 1'b0;
  logic stack_push = 1'b0, stack_pop = 1'b0, stack_load = 1'b0;
  logic [7:0] port0_latch = 8'hff, port2_latch = 8'hff, ram_wdata = 8'h00;
  logic [7:0] power_control_register = 8'h00, ram_addr = 8'h00;
  logic [1:0] bank_select = 2'h0;
  logic [2:0] work_reg_num = 3'h0;
  logic [6:0] bit_addr = 7'h00;
  logic [10:0] stack_load_val = 11'h000, stack_pointer_register;
  mmx_pkg::mmx_fetch_t fetch = '0;
  mmx_pkg::mmx_xdata_t xdata = '0;
  logic program_store_strobe, program_store_strobe_oe, address_latch_strobe;
  logic fetch_ready, xdata_ready, xdata_rd_n, xdata_wr_n, external_code_mode;
  logic download_mode, sfr_select, bit_value, mem_drive, program_store_strobe_wire;
  logic [7:0] port0_pins_out, port0_pins_oe, port2_pins, fetch_data, mem_q;
  logic [7:0] xdata_rdata, ram_rdata, work_reg_addr, port0_bus, r;
  logic [15:0] int_code_addr;
  logic [22:0] rows [4] = '{{2'h0, 3'h0, 1'h0, 8'h30, 8'h00, 1'h0},
    {2'h1, 3'h7, 1'h1, 8'h81, 8'h0f, 1'h0},
    {2'h2, 3'h3, 1'h0, 8'h80, 8'h13, 1'h1},
    {2'h3, 3'h7, 1'h0, 8'h7f, 8'h1f, 1'h0}};
  int fails = 0, checks_done = 0;
  // open-drain port 0 with board pull-up; strap resistor on the strobe
  assign port0_bus = (port0_pins_oe & port0_pins_out)
    | (~port0_pins_oe & (mem_drive ? mem_q : 8'hff));
  assign program_store_strobe_wire = program_store_strobe_oe ? program_store_strobe : program_store_strobe_strap;
  always #10 ref_clk = ~ref_clk;
  mmx_memory_map i_mmx_memory_map (.program_store_strobe_in(program_store_strobe_wire),
    .port0_pins_in(port0_bus), .int_code_data(int_code_addr[15:8]
    ^ int_code_addr[7:0] ^ 8'h5a), .*);
  mmx_ext_mem i_mmx_ext_mem (.ref_clk, .ale(address_latch_strobe),
    .program_store_strobe_n(program_store_strobe_wire), .rd_n(xdata_rd_n), .wr_n(xdata_wr_n), .ad(port0_bus),
    .hi(port2_pins), .drive(mem_drive), .q(mem_q));
  // ****************************
  // tasks
  // ****************************
  task automatic chk(input logic [10:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // select pin and strap set under reset; strap returns high three clocks after release
  task automatic rst_seq(input logic ea, strap);
    @(posedge ref_clk);
    rst <= 1'b1; external_access_select <= ea; program_store_strobe_strap <= strap;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    program_store_strobe_strap <= 1'b1;
    #1;
  endtask : rst_seq
  // request held until ready is seen, released on the following edge
  task automatic xfer(input logic dat, wr, input logic [23:0] a,
    input logic [7:0] w, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    if (dat) xdata <= '{a, w, wr, 1'b1};
    else fetch <= '{a[15:0], 1'b1};
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (!(dat ? xdata_ready : fetch_ready) && n < 40);
    if (n >= 40) fails++;
    @(posedge ref_clk);
    fetch.req <= 1'b0; xdata.req <= 1'b0;
    #1 rd = dat ? xdata_rdata : fetch_data;
  endtask : xfer
  task automatic ram_acc(input logic we, ind, input logic [7:0] a, d);
    @(posedge ref_clk);
    ram_we <= we; ram_indirect <= ind; ram_addr <= a; ram_wdata <= d;
    @(posedge ref_clk);
    ram_we <= 1'b0;
    #1;
  endtask : ram_acc
  task automatic sp_op(input logic push, load, input logic [10:0] v);
    @(posedge ref_clk);
    stack_push <= push; stack_load <= load; stack_load_val <= v;
    @(posedge ref_clk);
    stack_push <= 1'b0; stack_load <= 1'b0;
    #1;
  endtask : sp_op
  // ****************************
  // test sequence
  // ****************************
  initial begin
    rst_seq(1'b1, 1'b1);
    chk(stack_pointer_register, 11'h007);
    chk(external_code_mode, 1'b0);
    foreach (rows[i]) begin
      @(posedge ref_clk);
      {bank_select, work_reg_num, ram_indirect, ram_addr} <= rows[i][22:9];
      #1 chk(work_reg_addr, rows[i][8:1]);
      chk(sfr_select, rows[i][0]);
    end
    xfer(1'b0, 1'b0, 24'h001234, 8'h00, r);
    chk(r, 8'h7c);
    xfer(1'b0, 1'b0, 24'h00f800, 8'h00, r);
    chk(r, 8'h00);
    xfer(1'b0, 1'b0, 24'h00ffff, 8'h00, r);
    chk(r, 8'h00);
    ram_acc(1'b1, 1'b1, 8'h90, 8'h5a);
    ram_acc(1'b1, 1'b0, 8'h90, 8'ha5);
    ram_acc(1'b0, 1'b1, 8'h90, 8'h00);
    chk(ram_rdata, 8'h5a);
    ram_acc(1'b1, 1'b0, 8'h21, 8'h00);
    @(posedge ref_clk);
    bit_addr <= 7'h0b; bit_wdata <= 1'b1; bit_we <= 1'b1;
    @(posedge ref_clk);
    bit_we <= 1'b0;
    #1 chk(bit_value, 1'b1);
    ram_acc(1'b0, 1'b1, 8'h21, 8'h00);
    chk(ram_rdata, 8'h08);
    sp_op(1'b1, 1'b0, 11'h000);
    chk(stack_pointer_register, 11'h008);
    @(posedge ref_clk);
    extended_stack_enable <= 1'b1;
    sp_op(1'b0, 1'b1, 11'h0ff);
    sp_op(1'b1, 1'b0, 11'h000);
    chk(stack_pointer_register, 11'h100);
    @(posedge ref_clk);
    stack_pop <= 1'b1;
    @(posedge ref_clk);
    stack_pop <= 1'b0;
    #1 chk(stack_pointer_register, 11'h0ff);
    @(posedge ref_clk);
    extended_stack_enable <= 1'b0;
    sp_op(1'b1, 1'b0, 11'h000);
    chk(stack_pointer_register, 11'h000);
    @(posedge ref_clk);
    power_control_register <= 8'h10; // latch strobe off only
    repeat (12) @(posedge ref_clk);
    power_control_register <= 8'h00;
    rst_seq(1'b1, 1'b0);
    chk(download_mode, 1'b1);
    rst_seq(1'b0, 1'b1);
    chk(external_code_mode, 1'b1);
    xfer(1'b0, 1'b0, 24'h003c81, 8'h00, r);
    chk(r, 8'h42);
    xfer(1'b1, 1'b1, 24'h012345, 8'h9e, r);
    xfer(1'b1, 1'b0, 24'h012345, 8'h00, r);
    chk(r, 8'h9e);
    tally_and_finish();
  end
  // cut a hang short well past the expected hundred or so cycles
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_top
